/* File: rtl/pll_ctl_pkg.sv */
package pll_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Divider ranges
  // ---------------------------------------------------------------------------
  localparam int DIV_MIN      = 1;   // Least input and output divide value.
  localparam int DIV_MAX      = 32;  // Largest divide value of every counter.
  localparam int MULT_MIN     = 2;   // Least feedback multiply value.
  localparam int DIV_W        = 6;   // Width of a divide value field.
  localparam int CNT_W        = 11;  // Width of internal period counters.

  // ---------------------------------------------------------------------------
  // Reference pin selection and net map
  // ---------------------------------------------------------------------------
  localparam int REF_PINS     = 4;   // Dedicated clock pins.
  localparam int LOOP_A_PIN0  = 0;   // First pin of the first loop.
  localparam int LOOP_A_PIN1  = 1;   // Second pin of the first loop.
  localparam int LOOP_B_PIN0  = 2;   // First pin of the second loop.
  localparam int LOOP_B_PIN1  = 3;   // Second pin of the second loop.
  localparam int NETS         = 8;   // Global nets.
  localparam logic [7:0] A_DIVA_NETS = 8'h06;  // Nets 1 and 2.
  localparam logic [7:0] A_DIVB_NETS = 8'h09;  // Nets 0 and 3.
  localparam logic [7:0] B_DIVA_NETS = 8'h60;  // Nets 5 and 6.
  localparam logic [7:0] B_DIVB_NETS = 8'h90;  // Nets 4 and 7.

  // ---------------------------------------------------------------------------
  // Lock detection
  // ---------------------------------------------------------------------------
  localparam int LOCK_GOOD    = 4;   // Matching reference periods for lock.
  localparam int LOCK_TOL     = 1;   // Period mismatch still counted a match.
  localparam int WARMUP_NS    = 500; // Least settle time after a restart.
  localparam int CLK_NS       = 50;  // Period of the system clock.
  localparam int WARMUP_CYC   = (WARMUP_NS + CLK_NS - 1) / CLK_NS;

endpackage

/* File: rtl/edge_rise.sv */
`timescale 1ns/1ps
`default_nettype none

// Rising edge detector on a clock-synchronous input level.
module edge_rise (
  input  wire logic CLK_I,
  input  wire logic SYS_RST_I,
  input  wire logic level_i,
  output logic      rise_o
);

  // ---------------------------------------------------------------------------
  // Previous level store
  // ---------------------------------------------------------------------------
  logic prev; // Level seen on the last edge.

  // Remember the level so a rising edge is one clean pulse.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;

endmodule

`default_nettype wire

/* File: rtl/clk_div.sv */
`timescale 1ns/1ps
`default_nettype none

// Programmable divider stepped by a tick; output toggles at half period.
module clk_div #(
  parameter int W = 6
) (
  input  wire logic         CLK_I,
  input  wire logic         SYS_RST_I,
  input  wire logic         clear_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o,
  output logic              clk_o
);

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  logic [W-1:0] cnt;     // Ticks seen in the present output period.
  logic [W-1:0] half;    // Tick index where the output falls.

  assign half   = div_i >> 1;
  assign tick_o = tick_i & (cnt == div_i - W'(1));

  // Clear returns the count to its initial value of zero.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cnt   <= '0;
      clk_o <= 1'b0;
    end else if (clear_i) begin
      cnt   <= '0;
      clk_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt >= div_i - W'(1)) begin
        // Period wrap: output rises at count zero.
        cnt   <= '0;
        clk_o <= 1'b1;
      end else begin
        cnt   <= cnt + W'(1);
        // Divide by one keeps the output high; otherwise fall at half.
        clk_o <= (div_i == W'(1)) ? 1'b1 : (cnt + W'(1) < half ||
                 half == '0) ? clk_o : 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/pll_ctl.sv */
`timescale 1ns/1ps
`default_nettype none

module pll_ctl #(
  parameter int DIVW = pll_ctl_pkg::DIV_W
) (
  input  wire logic            CLK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic [3:0]      REF_PIN_I,
  input  wire logic            REF_SEL_I,
  input  wire logic            REF_DIFF_I,
  input  wire logic            RUN_EN_I,
  input  wire logic            CNT_CLEAR_I,
  input  wire logic            DET_GATE_I,
  input  wire logic [DIVW-1:0] IN_DIV_I,
  input  wire logic [DIVW-1:0] MULT_I,
  input  wire logic [DIVW-1:0] DIV_A_I,
  input  wire logic [DIVW-1:0] DIV_B_I,
  input  wire logic [DIVW-1:0] DIV_E_I,
  input  wire logic            SWAP_I,
  input  wire logic            COMP_SEL_I,
  input  wire logic            INV_CORE0_I,
  input  wire logic            INV_CORE1_I,
  input  wire logic            EXT_EN_I,
  input  wire logic            GPIO_OUT_I,
  input  wire logic            GPIO_OE_I,
  input  wire logic            LOOP_B_I,
  output logic                 CORE0_O,
  output logic                 CORE1_O,
  output logic [7:0]           NET_O,
  output logic                 EXT_PIN_O,
  output logic                 EXT_PIN_OE_O,
  output logic                 UP_O,
  output logic                 DOWN_O,
  output logic                 LOCKED_O,
  output logic                 CFG_ERR_O
);

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  // Divider fields must hold the largest value of 32.
  if (DIVW < pll_ctl_pkg::DIV_W) begin : g_bad_width
    $error("Divider width too small for the divide range.");
  end

  // ---------------------------------------------------------------------------
  // Hold conditions and reference selection
  // ---------------------------------------------------------------------------
  logic hold;       // Loop is held in reset by enable or clear.
  logic ref_lvl;    // Selected reference pin level.
  logic ref_rise;   // One pulse per reference rising edge.
  logic restart;    // Pulse when hold ends, to reacquire.
  logic [1:0] pin0; // Index of the first pin of this loop.

  // Low enable or high clear both hold the whole loop.
  assign hold = ~RUN_EN_I | CNT_CLEAR_I;

  // Loop A sees pins 0/1 only, loop B pins 2/3 only.
  assign pin0 = LOOP_B_I ? 2'(pll_ctl_pkg::LOOP_B_PIN0)
                         : 2'(pll_ctl_pkg::LOOP_A_PIN0);

  // Differential uses both pins of the loop as a pair: first pin true,
  // second complement. A level match is required for a valid edge.
  always_comb begin
    if (REF_DIFF_I) begin
      ref_lvl = REF_PIN_I[pin0] & ~REF_PIN_I[pin0 + 2'(1)];
    end else begin
      ref_lvl = REF_PIN_I[pin0 + 2'(REF_SEL_I)];
    end
  end

  edge_rise u_ref_edge (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .level_i   (ref_lvl),
    .rise_o    (ref_rise)
  );

  edge_rise u_restart (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .level_i   (~hold),
    .rise_o    (restart)
  );

  // ---------------------------------------------------------------------------
  // Configuration range check
  // ---------------------------------------------------------------------------
  logic cfg_ok; // All divide values inside the legal range.

  // Out-of-range values hold the loop idle rather than run wild.
  always_comb begin
    cfg_ok = 1'b1;
    if (IN_DIV_I < DIVW'(pll_ctl_pkg::DIV_MIN) ||
        IN_DIV_I > DIVW'(pll_ctl_pkg::DIV_MAX)) cfg_ok = 1'b0;
    if (MULT_I < DIVW'(pll_ctl_pkg::MULT_MIN) ||
        MULT_I > DIVW'(pll_ctl_pkg::DIV_MAX)) cfg_ok = 1'b0;
    if (DIV_A_I < DIVW'(pll_ctl_pkg::DIV_MIN) ||
        DIV_A_I > DIVW'(pll_ctl_pkg::DIV_MAX)) cfg_ok = 1'b0;
    if (DIV_B_I < DIVW'(pll_ctl_pkg::DIV_MIN) ||
        DIV_B_I > DIVW'(pll_ctl_pkg::DIV_MAX)) cfg_ok = 1'b0;
    if (DIV_E_I < DIVW'(pll_ctl_pkg::DIV_MIN) ||
        DIV_E_I > DIVW'(pll_ctl_pkg::DIV_MAX)) cfg_ok = 1'b0;
  end

  assign CFG_ERR_O = ~cfg_ok;

  logic stop; // Loop stopped by hold or bad setting.
  assign stop = hold | ~cfg_ok;

  // ---------------------------------------------------------------------------
  // Input divider: reference ticks
  // ---------------------------------------------------------------------------
  logic ref_tick; // Divided reference event to the detector.

  clk_div #(.W(DIVW)) u_in_div (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .clear_i   (stop),
    .tick_i    (ref_rise),
    .div_i     (IN_DIV_I),
    .tick_o    (ref_tick),
    .clk_o     ()
  );

  // ---------------------------------------------------------------------------
  // Oscillator model: a phase step of M per system clock cycle
  // ---------------------------------------------------------------------------
  // The oscillator is a digital rate generator. It issues M ticks per
  // measured reference period, spaced period/M apart, so outputs run at
  // in * M / (N * D) for a divide value D. Period resolution is the system clock, a known limit.
  logic [pll_ctl_pkg::CNT_W-1:0] ref_period; // Cycles since last tick.
  logic [pll_ctl_pkg::CNT_W-1:0] period;     // Learned reference period.
  logic [pll_ctl_pkg::CNT_W-1:0] acc;        // Oscillator phase accum.
  logic [pll_ctl_pkg::CNT_W+5:0] acc_next;   // Accumulator step.
  logic                          osc_tick;   // One oscillator step.
  logic                          fb_tick;    // Feedback divider wrap.
  logic                          up;         // Detector wants faster.
  logic                          down;       // Detector wants slower.

  // Measure the reference period between divided ticks.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ref_period <= '0;
    end else if (stop || ref_tick) begin
      ref_period <= '0;
    end else if (ref_period != '1) begin
      ref_period <= ref_period + pll_ctl_pkg::CNT_W'(1);
    end
  end

  // Detector compares feedback with the reference; gated off, no steps.
  assign up   = DET_GATE_I & ref_tick & ~fb_tick;
  assign down = DET_GATE_I & fb_tick & ~ref_tick;

  // Period register loads only on divided reference ticks with the detector on and clears on stop, so a gated detector
  // keeps the last rate and the outputs keep toggling.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      period <= '0;
    end else if (stop) begin
      period <= '0;
    end else if (DET_GATE_I && ref_tick) begin
      period <= ref_period + pll_ctl_pkg::CNT_W'(1);
    end
  end

  // Each cycle adds M; a tick fires each time a whole period is passed.
  assign acc_next = {6'h00, acc} + {{(pll_ctl_pkg::CNT_W){1'b0}}, MULT_I};

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      acc      <= '0;
      osc_tick <= 1'b0;
    end else if (stop || period == '0 || (DET_GATE_I && ref_tick)) begin
      // Realign phase at every divided reference tick while the detector runs.
      // The edge itself is step zero, so each period still holds M steps.
      acc      <= '0;
      osc_tick <= ~stop & (period != '0);
    end else if (acc_next >= {6'h00, period}) begin
      acc      <= pll_ctl_pkg::CNT_W'(acc_next - {6'h00, period});
      osc_tick <= 1'b1;
    end else begin
      acc      <= pll_ctl_pkg::CNT_W'(acc_next);
      osc_tick <= 1'b0;
    end
  end

  // Feedback divider by M closes the loop back to the detector.
  clk_div #(.W(DIVW)) u_fb_div (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .clear_i   (stop | (DET_GATE_I & ref_tick)),
    .tick_i    (osc_tick),
    .div_i     (MULT_I),
    .tick_o    (fb_tick),
    .clk_o     ()
  );

  // Registered detector outputs for observation.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      UP_O   <= 1'b0;
      DOWN_O <= 1'b0;
    end else begin
      UP_O   <= up & ~stop;
      DOWN_O <= down & ~stop;
    end
  end

  // ---------------------------------------------------------------------------
  // Output dividers
  // ---------------------------------------------------------------------------
  logic div_a_clk; // Global divider A output.
  logic div_b_clk; // Global divider B output.
  logic div_e_clk; // External divider output.

  clk_div #(.W(DIVW)) u_div_a (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .clear_i   (stop),
    .tick_i    (osc_tick),
    .div_i     (DIV_A_I),
    .tick_o    (),
    .clk_o     (div_a_clk)
  );

  clk_div #(.W(DIVW)) u_div_b (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .clear_i   (stop),
    .tick_i    (osc_tick),
    .div_i     (DIV_B_I),
    .tick_o    (),
    .clk_o     (div_b_clk)
  );

  clk_div #(.W(DIVW)) u_div_e (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .clear_i   (stop),
    .tick_i    (osc_tick),
    .div_i     (DIV_E_I),
    .tick_o    (),
    .clk_o     (div_e_clk)
  );

  // ---------------------------------------------------------------------------
  // Core outputs, net routing and external pin
  // ---------------------------------------------------------------------------
  logic core0; // Core output 0 before inversion.
  logic core1; // Core output 1 before inversion.

  // Either global divider may drive either core output.
  assign core0 = SWAP_I ? div_b_clk : div_a_clk;
  assign core1 = SWAP_I ? div_a_clk : div_b_clk;

  // Outputs registered; forced low whenever the loop is held.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CORE0_O <= 1'b0;
      CORE1_O <= 1'b0;
    end else if (stop) begin
      CORE0_O <= 1'b0;
      CORE1_O <= 1'b0;
    end else begin
      // Local inversion applies at the point of use only.
      CORE0_O <= core0 ^ INV_CORE0_I;
      CORE1_O <= core1 ^ INV_CORE1_I;
    end
  end

  // Fixed net map: divider A and B each reach two nets per loop.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      NET_O <= '0;
    end else if (stop) begin
      NET_O <= '0;
    end else if (LOOP_B_I) begin
      NET_O <= (pll_ctl_pkg::B_DIVA_NETS & {8{div_a_clk}}) |
               (pll_ctl_pkg::B_DIVB_NETS & {8{div_b_clk}});
    end else begin
      NET_O <= (pll_ctl_pkg::A_DIVA_NETS & {8{div_a_clk}}) |
               (pll_ctl_pkg::A_DIVB_NETS & {8{div_b_clk}});
    end
  end

  // External pin: only the external divider drives it; when unused the
  // pin is handed back to general I/O use.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      EXT_PIN_O    <= 1'b0;
      EXT_PIN_OE_O <= 1'b0;
    end else if (EXT_EN_I) begin
      EXT_PIN_O    <= div_e_clk & ~stop;
      EXT_PIN_OE_O <= 1'b1;
    end else begin
      EXT_PIN_O    <= GPIO_OUT_I;
      EXT_PIN_OE_O <= GPIO_OE_I;
    end
  end

  // ---------------------------------------------------------------------------
  // Lock detect
  // ---------------------------------------------------------------------------
  // Lock is a run of matching reference periods after a settle time. A
  // single mismatch drops it, so it may pulse during acquisition.
  logic [3:0] good;     // Consecutive matching periods.
  logic [4:0] warm;     // Settle countdown after restart.
  logic       match;    // Measured period within tolerance of the last one.
  logic [pll_ctl_pkg::CNT_W-1:0] last; // Previous measured period.

  assign match = (ref_period + pll_ctl_pkg::CNT_W'(1) <=
                  last + pll_ctl_pkg::CNT_W'(pll_ctl_pkg::LOCK_TOL)) &&
                 (ref_period + pll_ctl_pkg::CNT_W'(pll_ctl_pkg::LOCK_TOL + 1)
                  >= last);

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      warm <= '0;
    end else if (stop || restart) begin
      warm <= 5'(pll_ctl_pkg::WARMUP_CYC);
    end else if (warm != '0) begin
      warm <= warm - 5'(1);
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      good <= '0;
      last <= '0;
    end else if (stop) begin
      good <= '0;
      last <= '0;
    end else if (ref_tick) begin
      last <= ref_period + pll_ctl_pkg::CNT_W'(1);
      if (match && good != 4'(pll_ctl_pkg::LOCK_GOOD)) begin
        good <= good + 4'(1);
      end else if (!match) begin
        good <= '0;
      end
    end
  end

  // Lock held low throughout hold; high only after the settle time with LOCK_GOOD matching periods.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      LOCKED_O <= 1'b0;
    end else if (stop) begin
      LOCKED_O <= 1'b0;
    end else begin
      LOCKED_O <= (warm == '0) &&
                  (good == 4'(pll_ctl_pkg::LOCK_GOOD));
    end
  end

  // No compensated output is built; the compensation select is accepted
  // and left unused.
  logic comp_unused; // Selection kept for configuration visibility.
  assign comp_unused = COMP_SEL_I;

endmodule

`default_nettype wire

/* File: verification/pll_ctl_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// Port checker for the loop block; it sees only the top module's pins.
module pll_ctl_sva #(
  parameter int DIVW = pll_ctl_pkg::DIV_W
) (
  input wire logic            CLK_I,
  input wire logic            SYS_RST_I,
  input wire logic            RUN_EN_I,
  input wire logic            CNT_CLEAR_I,
  input wire logic            DET_GATE_I,
  input wire logic [DIVW-1:0] IN_DIV_I,
  input wire logic [DIVW-1:0] MULT_I,
  input wire logic [DIVW-1:0] DIV_A_I,
  input wire logic [DIVW-1:0] DIV_B_I,
  input wire logic [DIVW-1:0] DIV_E_I,
  input wire logic            EXT_EN_I,
  input wire logic            GPIO_OUT_I,
  input wire logic            GPIO_OE_I,
  input wire logic            LOOP_B_I,
  input wire logic            CORE0_O,
  input wire logic            CORE1_O,
  input wire logic [7:0]      NET_O,
  input wire logic            EXT_PIN_O,
  input wire logic            EXT_PIN_OE_O,
  input wire logic            UP_O,
  input wire logic            DOWN_O,
  input wire logic            LOCKED_O,
  input wire logic            CFG_ERR_O
);
  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  logic [1:0] age;  // Edges since reset; the first edges still echo reset.
  logic       off;  // Loop held off by the enable or by the clear.
  logic       bad;  // Some divide value lies outside its range.

  function automatic logic out_rng(input logic [DIVW-1:0] v, input int lo);
    return (int'(v) < lo) || (int'(v) > pll_ctl_pkg::DIV_MAX);
  endfunction

  // Age counter saturates so that it costs nothing over a long run.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  assign off = !RUN_EN_I || CNT_CLEAR_I;
  assign bad = out_rng(IN_DIV_I, 1) || out_rng(MULT_I, 2)
            || out_rng(DIV_A_I, 1) || out_rng(DIV_B_I, 1)
            || out_rng(DIV_E_I, 1);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  off_zero_a: assert property (off |=> !CORE0_O && !CORE1_O
    && NET_O == 8'h00) else $error("Clock outputs ran while held off.");
  clear_quiet_a: assert property (CNT_CLEAR_I |=> !LOCKED_O
    && !UP_O && !DOWN_O) else $error("Clear did not silence the loop.");
  lock_low_a: assert property (!RUN_EN_I |=> !LOCKED_O)
    else $error("Lock shown while disabled.");
  gate_quiet_a: assert property (!DET_GATE_I |=> !UP_O && !DOWN_O)
    else $error("Detector pulsed while gated.");
  enable_settle_a: assert property ($rose(RUN_EN_I) |-> !LOCKED_O [*8])
    else $error("Lock shown too soon after enable.");
  clear_settle_a: assert property ($fell(CNT_CLEAR_I) |-> !LOCKED_O [*8])
    else $error("Lock shown too soon after clear.");
  nets_first_a: assert property (!LOOP_B_I |=> NET_O[7:4] == 4'h0
    && NET_O[1] == NET_O[2] && NET_O[0] == NET_O[3])
    else $error("First loop net map wrong.");
  nets_second_a: assert property (LOOP_B_I |=> NET_O[3:0] == 4'h0
    && NET_O[5] == NET_O[6] && NET_O[4] == NET_O[7])
    else $error("Second loop net map wrong.");
  pin_gpio_a: assert property (age == 2'h3 && !EXT_EN_I |=>
    EXT_PIN_O == $past(GPIO_OUT_I) && EXT_PIN_OE_O == $past(GPIO_OE_I))
    else $error("Unused external pin not general I/O.");
  ext_off_a: assert property (EXT_EN_I && off |=> !EXT_PIN_O)
    else $error("External clock ran while held off.");
  range_flag_a: assert property (CFG_ERR_O == bad)
    else $error("Range flag disagrees with divide values.");
  range_stop_a: assert property (CFG_ERR_O |=> !LOCKED_O
    && NET_O == 8'h00) else $error("Loop ran with a bad divide value.");

  lock_seen_c: cover property ($rose(LOCKED_O));
  gated_lock_c: cover property (!DET_GATE_I && LOCKED_O);
  range_seen_c: cover property (CFG_ERR_O);
  ext_run_c: cover property (EXT_EN_I && EXT_PIN_O);
endmodule

bind pll_ctl pll_ctl_sva #(.DIVW(DIVW)) u_sva (.*);

`default_nettype wire

/* File: verification/pll_ref_source.sv */
`timescale 1ns/1ps
`default_nettype none

// Model of the board side: drives the dedicated clock pins.
module pll_ref_source (
  input  wire logic       clk_i,   // System clock, for pacing only.
  input  wire logic       run_i,   // Reference runs while high.
  input  wire logic [7:0] half_i,  // Half period in system cycles.
  input  wire logic [1:0] pin_i,   // Pin carrying the true reference.
  input  wire logic       diff_i,  // Drive the pair pin as complement.
  output logic      [3:0] ref_o    // Dedicated clock pin levels.
);
  logic [7:0] cnt  = 8'h00;  // Cycles into the current half period.
  logic       ph   = 1'b0;   // Reference level; stands still when stopped.
  logic [2:0] junk = 3'h0;   // Chatter on pins that carry no reference.

  // Other pins chatter at another rate, so a wrong pin pick shows up.
  always @(posedge clk_i) begin
    junk <= #1 junk + 3'h1;
    if (run_i) begin
      cnt <= #1 (cnt + 8'h01 >= half_i) ? 8'h00 : cnt + 8'h01;
      if (cnt + 8'h01 >= half_i) begin
        ph <= #1 !ph;
      end
    end
  end

  // Only a dedicated pin carries the reference, and only one loop's pin.
  always_comb begin
    ref_o = {4{junk[2]}} ^ 4'h5;
    ref_o[pin_i] = ph;
    if (diff_i) begin
      ref_o[pin_i ^ 2'h1] = !ph;
    end
  end
endmodule

`default_nettype wire

/* File: verification/pll_control_and_clock_routing_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module pll_control_and_clock_routing_bench;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam int WIN  = 1000;  // Measuring window in cycles.
  localparam int HALF = 20;    // Reference half period in cycles.
  logic       CLK_I = 1'b0, SYS_RST_I = 1'b1, REF_SEL_I, REF_DIFF_I;
  logic       RUN_EN_I, CNT_CLEAR_I, DET_GATE_I, SWAP_I, COMP_SEL_I;
  logic       INV_CORE0_I, INV_CORE1_I, EXT_EN_I, GPIO_OUT_I, GPIO_OE_I;
  logic       LOOP_B_I, CORE0_O, CORE1_O, EXT_PIN_O, EXT_PIN_OE_O;
  logic       UP_O, DOWN_O, LOCKED_O, CFG_ERR_O, ref_run, ref_diff;
  logic [3:0] REF_PIN_I;
  logic [5:0] IN_DIV_I, MULT_I, DIV_A_I, DIV_B_I, DIV_E_I;
  logic [7:0] NET_O;
  logic [1:0] ref_pin;
  int         failures = 0, n_compared = 0, c0, c1, cn, ce;

  always #25 CLK_I = ~CLK_I;

  pll_ctl u_dut (.*);
  pll_ref_source u_src (.clk_i(CLK_I), .run_i(ref_run), .half_i(8'(HALF)),
    .pin_i(ref_pin), .diff_i(ref_diff), .ref_o(REF_PIN_I));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Inputs move one nanosecond after an edge, outputs are settled then.
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  // Expected rising edges in a window; edge counting allows one of slack.
  function automatic int rises(input int dv);
    return WIN * int'(MULT_I) / (int'(IN_DIV_I) * dv * 2 * HALF);
  endfunction
  function automatic int near(input int seen, exp);
    return (seen >= exp - 1 && seen <= exp + 1) ? exp : seen;
  endfunction

  task automatic measure(input int idx);
    logic [3:0] p;
    p = {CORE0_O, CORE1_O, NET_O[idx], EXT_PIN_O};
    {c0, c1, cn, ce} = '0;
    repeat (WIN) begin
      cyc(1);
      c0 += int'(CORE0_O && !p[3]);
      c1 += int'(CORE1_O && !p[2]);
      cn += int'(NET_O[idx] && !p[1]);
      ce += int'(EXT_PIN_O && !p[0]);
      p = {CORE0_O, CORE1_O, NET_O[idx], EXT_PIN_O};
    end
  endtask

  // Lock may bounce while it settles, so it is checked again later.
  task automatic wait_lock();
    int k;
    for (k = 0; k < 3000 && LOCKED_O !== 1'b1; k++) cyc(1);
    cyc(40);
    check("locked", LOCKED_O, 1'b1);
  endtask

  task automatic print_verdict();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Watchdog: the tests need about five thousand cycles.
  // ---------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge CLK_I);
    failures++;
    print_verdict();
  end

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    {REF_SEL_I, REF_DIFF_I, RUN_EN_I, CNT_CLEAR_I, SWAP_I} = '0;
    {COMP_SEL_I, INV_CORE0_I, INV_CORE1_I, GPIO_OUT_I, GPIO_OE_I} = '0;
    {LOOP_B_I, ref_diff, EXT_EN_I} = '0;
    {DET_GATE_I, ref_run, ref_pin} = 4'hD;
    {IN_DIV_I, MULT_I, DIV_A_I, DIV_B_I, DIV_E_I} = {6'd1, 6'd4, 6'd2,
      6'd5, 6'd4};
    cyc(4);
    SYS_RST_I = 1'b0;
    cyc(2);
    check("lock idle", LOCKED_O, 1'b0);
    check("nets idle", NET_O, 8'h00);
    REF_SEL_I = 1'b1;
    EXT_EN_I = 1'b1;
    RUN_EN_I = 1'b1;
    wait_lock();
    measure(1);
    check("core0 A", near(c0, rises(2)), rises(2));
    check("core1 B", near(c1, rises(5)), rises(5));
    check("net1 A", near(cn, rises(2)), rises(2));
    check("ext E", near(ce, rises(4)), rises(4));
    SWAP_I = 1'b1;
    INV_CORE1_I = 1'b1;
    measure(0);
    check("core0 swap", near(c0, rises(5)), rises(5));
    check("core1 inv", near(c1, rises(2)), rises(2));
    check("net0 B", near(cn, rises(5)), rises(5));
    DET_GATE_I = 1'b0;
    ref_run = 1'b0;
    measure(1);
    check("gated run", near(cn, rises(2)), rises(2));
    check("gated up", UP_O, 1'b0);
    check("gated down", DOWN_O, 1'b0);
    DET_GATE_I = 1'b1;
    ref_run = 1'b1;
    CNT_CLEAR_I = 1'b1;
    cyc(3);
    check("clear lock", LOCKED_O, 1'b0);
    check("clear nets", NET_O, 8'h00);
    CNT_CLEAR_I = 1'b0;
    wait_lock();
    RUN_EN_I = 1'b0;
    cyc(3);
    check("off lock", LOCKED_O, 1'b0);
    check("off core", {CORE0_O, CORE1_O, EXT_PIN_O}, 3'h0);
    {LOOP_B_I, REF_DIFF_I, REF_SEL_I, ref_diff, ref_pin} = 6'h36;
    RUN_EN_I = 1'b1;
    wait_lock();
    measure(5);
    check("net5 A", near(cn, rises(2)), rises(2));
    check("core0 B", near(c0, rises(5)), rises(5));
    for (int i = 0; i < 4; i++) begin
      MULT_I = (i == 0) ? 6'd1 : (i == 1) ? 6'd33 : 6'd4;
      DIV_A_I = (i == 2) ? 6'd0 : (i == 3) ? 6'd33 : 6'd2;
      cyc(3);
      check("range flag", CFG_ERR_O, 1'b1);
      check("range lock", LOCKED_O, 1'b0);
    end
    {MULT_I, DIV_A_I} = {6'd4, 6'd2};
    {EXT_EN_I, GPIO_OUT_I, GPIO_OE_I} = 3'h3;
    cyc(2);
    check("gpio hi", {EXT_PIN_O, EXT_PIN_OE_O}, 2'h3);
    GPIO_OUT_I = 1'b0;
    cyc(2);
    check("gpio lo", {EXT_PIN_O, EXT_PIN_OE_O}, 2'h1);
    print_verdict();
  end
endmodule

`default_nettype wire
